// >>> rtl/asct_defs.vh
// Pin timing constants and cycle counts for the static memory controller
`ifndef ASCT_DEFS_VH
`define ASCT_DEFS_VH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define ASCT_CLK_PERIOD_NS          5

// ----------------------------------------------------------------------------
// Memory timing in ns, as printed
// ----------------------------------------------------------------------------
`define ASCT_ADDRESS_ACCESS_TIME_NS 55
`define ASCT_READ_CYCLE_TIME_NS     55
`define ASCT_WRITE_CYCLE_TIME_NS    55
`define ASCT_WRITE_PULSE_WIDTH_NS   40
`define ASCT_WRITE_DATA_SETUP_NS    25
`define ASCT_OUTPUT_OFF_TIME_NS     20

// ----------------------------------------------------------------------------
// Derived cycle counts; least times round up, waits for the device round up
// ----------------------------------------------------------------------------
`define ASCT_CEIL_CYC(t) (((t) + `ASCT_CLK_PERIOD_NS - 1) / `ASCT_CLK_PERIOD_NS)
`define ASCT_ACCESS_CYC     `ASCT_CEIL_CYC(`ASCT_ADDRESS_ACCESS_TIME_NS)
`define ASCT_READ_CYC       `ASCT_CEIL_CYC(`ASCT_READ_CYCLE_TIME_NS)
`define ASCT_WRITE_CYC      `ASCT_CEIL_CYC(`ASCT_WRITE_CYCLE_TIME_NS)
`define ASCT_PULSE_CYC      `ASCT_CEIL_CYC(`ASCT_WRITE_PULSE_WIDTH_NS)
`define ASCT_SETUP_CYC      `ASCT_CEIL_CYC(`ASCT_WRITE_DATA_SETUP_NS)
`define ASCT_OFF_CYC        `ASCT_CEIL_CYC(`ASCT_OUTPUT_OFF_TIME_NS)

// ----------------------------------------------------------------------------
// Synchroniser depth on the data pins
// ----------------------------------------------------------------------------
`define ASCT_SYNC_STAGES    2

`endif

// >>> rtl/asct_sync.v
// Two-stage synchroniser for a bus of asynchronous input pins
`timescale 1ns/100ps

module asct_sync
#(
    parameter WIDTH = 16
)
(
    input  wire             clk_sys_i,
    input  wire             rstn_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    // ------------------------------------------------------------------------
    // Per-bit flop pair
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg meta_reg;
            reg stable_reg;
            // First flop feeds only the second
            always @(posedge clk_sys_i)
            begin
                if (!rstn_i)
                begin
                    meta_reg   <= 1'b0;
                    stable_reg <= 1'b0;
                end
                else
                begin
                    meta_reg   <= async_i[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_o[i] = stable_reg;
        end
    endgenerate

endmodule // asct_sync

// >>> rtl/asct_ctrl.v
// Host-side controller that runs read and write cycles on a 2M x 16 static memory
// Function
// (RQ1) Select only when low select low, high select high
// (RQ2) Both lanes high or deselected means standby
// (RQ3) Read data valid 55 ns; reads 55 ns apart
// (RQ4) Old data held 10 ns after address change
// (RQ5) Read data valid 55 ns after select
// (RQ6) Data valid 25 ns after output enable
// (RQ7) Lane data valid 55 ns after lane enable
// (RQ8) Outputs float within 20 ns of deassert
// (RQ9) Deselect powers down within 55 ns
// (RQ10) Address valid no later than read strobe
// (RQ11) Write is overlap of all strobes
// (RQ12) Data timing referenced to write-ending edge
// (RQ13) Address 40 ns before end; writes 55 ns apart
// (RQ14) Address may change right at write end
// (RQ15) Address valid at write start, zero setup
// (RQ16) Each write strobe low at least 40 ns
// (RQ17) Write data valid 25 ns before end
// (RQ18) Write enable low turns outputs off
// (RQ19) Pins float during write with output enable high
// (RQ20) Select and write enable release together stay floating
// (RQ21) Never drive pins while memory drives them
// (RQ22) Low lane bits 0-7, high lane 8-15
// (RQ23) Memory drives only in an enabled read
`timescale 1ns/100ps
`include "asct_defs.vh"

module asct_ctrl
#(
    parameter ADDR_W = 21,
    parameter DATA_W = 16
)
(
    input  wire              clk_sys_i,
    input  wire              rstn_i,
    // User request port
    input  wire              req_i,
    input  wire              req_write_i,
    input  wire [ADDR_W-1:0] req_addr_i,
    input  wire [DATA_W-1:0] req_wdata_i,
    input  wire [1:0]        req_lanes_i,
    output reg               ready_o,
    output reg               done_o,
    output reg  [DATA_W-1:0] rdata_o,
    // Memory pins
    output reg  [ADDR_W-1:0] mem_addr_o,
    output reg               select_low_active_n_o,
    output reg               select_high_active_o,
    output reg               mem_write_n_o,
    output reg               mem_output_n_o,
    output reg               upper_lane_enable_n_o,
    output reg               lower_lane_enable_n_o,
    output reg  [DATA_W-1:0] mem_data_o,
    output reg               mem_data_oe_o,
    input  wire [DATA_W-1:0] mem_data_i
);

    // ------------------------------------------------------------------------
    // States and counts
    // ------------------------------------------------------------------------
    localparam [1:0] ST_IDLE    = 2'b00;
    localparam [1:0] ST_READ    = 2'b01;
    localparam [1:0] ST_WRITE   = 2'b10;
    localparam [1:0] ST_RECOVER = 2'b11;

    // Counts worked out at integer width, then cut to the counter width
    localparam integer READ_CYC_INT  = `ASCT_ACCESS_CYC + `ASCT_SYNC_STAGES + 1;
    localparam integer PULSE_CYC_INT = `ASCT_PULSE_CYC;
    localparam integer WPAD_CYC_INT  = `ASCT_WRITE_CYC - `ASCT_PULSE_CYC;
    localparam integer OFF_CYC_INT   = `ASCT_OFF_CYC;

    localparam [5:0] READ_LOAD  = READ_CYC_INT[5:0];
    localparam [5:0] PULSE_LOAD = PULSE_CYC_INT[5:0];
    localparam [5:0] WPAD_LOAD  = WPAD_CYC_INT[5:0];
    localparam [5:0] OFF_LOAD   = OFF_CYC_INT[5:0];

    reg  [1:0]        state_reg;
    reg  [1:0]        state_next;
    reg  [5:0]        cnt_reg;
    reg  [5:0]        cnt_next;
    reg               hold_reg;
    reg               hold_next;
    wire [DATA_W-1:0] data_sync;

    // ------------------------------------------------------------------------
    // Data pin synchroniser
    // ------------------------------------------------------------------------
    asct_sync
    #(
        .WIDTH     (DATA_W)
    )
    u_sync
    (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .async_i   (mem_data_i),
        .sync_o    (data_sync)
    );

    // ------------------------------------------------------------------------
    // State and counter next values
    // ------------------------------------------------------------------------
    always @*
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        hold_next  = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (req_i && ready_o)
                begin
                    state_next = req_i && req_write_i ? ST_WRITE : ST_READ;
                    cnt_next   = req_write_i ? PULSE_LOAD : READ_LOAD; // RQ16 RQ3
                end
            end
            ST_READ:
            begin
                cnt_next = cnt_reg - 6'h01;
                if (cnt_reg == 6'h01)
                begin
                    state_next = ST_RECOVER;
                    cnt_next   = OFF_LOAD; // RQ21
                end
            end
            ST_WRITE:
            begin
                cnt_next = cnt_reg - 6'h01;
                if (cnt_reg == 6'h01)
                begin
                    state_next = ST_RECOVER;
                    cnt_next   = WPAD_LOAD; // RQ13
                    hold_next  = 1'b1;      // RQ17
                end
            end
            default:
            begin
                cnt_next = cnt_reg - 6'h01;
                if (cnt_reg == 6'h01)
                begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Sequencer and pin registers
    // ------------------------------------------------------------------------
    always @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            state_reg             <= ST_IDLE;
            cnt_reg               <= 6'h00;
            hold_reg              <= 1'b0;
            ready_o               <= 1'b0;
            done_o                <= 1'b0;
            rdata_o               <= {DATA_W{1'b0}};
            mem_addr_o            <= {ADDR_W{1'b0}};
            select_low_active_n_o <= 1'b1; // RQ1
            select_high_active_o  <= 1'b0; // RQ1
            mem_write_n_o         <= 1'b1;
            mem_output_n_o        <= 1'b1;
            upper_lane_enable_n_o <= 1'b1; // RQ2
            lower_lane_enable_n_o <= 1'b1;
            mem_data_o            <= {DATA_W{1'b0}};
            mem_data_oe_o         <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            hold_reg  <= hold_next;
            done_o    <= 1'b0;
            ready_o   <= (state_next == ST_IDLE);
            // Start of a cycle: address with all strobes on one edge
            if (state_reg == ST_IDLE && state_next != ST_IDLE)
            begin
                mem_addr_o            <= req_addr_i;       // RQ10 RQ15
                select_low_active_n_o <= 1'b0;             // RQ1
                select_high_active_o  <= 1'b1;             // RQ1
                lower_lane_enable_n_o <= ~req_lanes_i[0];  // RQ22
                upper_lane_enable_n_o <= ~req_lanes_i[1];  // RQ22
                mem_write_n_o         <= ~req_write_i;     // RQ11
                mem_output_n_o        <= req_write_i;      // RQ19
                mem_data_o            <= req_wdata_i;      // RQ17
                mem_data_oe_o         <= req_write_i;      // RQ21
            end
            // End of read: take data, drop every strobe
            if (state_reg == ST_READ && state_next == ST_RECOVER)
            begin
                rdata_o               <= data_sync;        // RQ3 RQ5 RQ7
                select_low_active_n_o <= 1'b1;
                select_high_active_o  <= 1'b0;
                mem_output_n_o        <= 1'b1;             // RQ8
                upper_lane_enable_n_o <= 1'b1;
                lower_lane_enable_n_o <= 1'b1;
            end
            // End of write: all strobes released together
            if (state_reg == ST_WRITE && state_next == ST_RECOVER)
            begin
                mem_write_n_o         <= 1'b1;             // RQ11 RQ12
                select_low_active_n_o <= 1'b1;             // RQ20
                select_high_active_o  <= 1'b0;
                upper_lane_enable_n_o <= 1'b1;
                lower_lane_enable_n_o <= 1'b1;
            end
            // Data held one cycle past write end, then released
            if (hold_reg)
            begin
                mem_data_oe_o <= 1'b0;                     // RQ14 RQ17
            end
            // Completion pulse on return to idle
            if (state_reg == ST_RECOVER && state_next == ST_IDLE)
            begin
                done_o <= 1'b1;
            end
        end
    end

endmodule // asct_ctrl

// >>> verif/asct_chk.sv
// Pin timing assertions for the static memory controller
`timescale 1ns/100ps
module asct_chk (
    input logic        clk_sys_i,
    input logic        rstn_i,
    input logic        req_i,
    input logic        req_write_i,
    input logic        ready_o,
    input logic        done_o,
    input logic [20:0] mem_addr_o,
    input logic        select_low_active_n_o,
    input logic        select_high_active_o,
    input logic        mem_write_n_o,
    input logic        mem_output_n_o,
    input logic        mem_data_oe_o
);
    // Select taken from the low-active select pin alone
    wire sel = !select_low_active_n_o;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // Read request taken at this edge
    sequence rd_take_s; req_i && ready_o && !req_write_i; endsequence
    sel_pair_a: assert property (sel == select_high_active_o)
        else $error("selects split");
    addr_hold_a: assert property (sel && $past(sel) |-> $stable(mem_addr_o))
        else $error("address moved");
    wr_pulse_a: assert property ($fell(mem_write_n_o) |-> (!mem_write_n_o)[*8])
        else $error("write pulse short");
    wr_data_a: assert property (!mem_write_n_o |-> mem_data_oe_o ##1 mem_data_oe_o)
        else $error("write data dropped");
    no_clash_a: assert property (mem_data_oe_o |-> mem_output_n_o)
        else $error("drive clash");
    rd_len_a: assert property ($fell(mem_output_n_o) |->
        (!mem_output_n_o)[*8] ##1 (!mem_output_n_o)[*3]) else $error("read strobe short");
    rd_gap_a: assert property ($rose(mem_output_n_o) |-> select_low_active_n_o[*4])
        else $error("no float gap");
    wr_gap_a: assert property ($fell(mem_write_n_o) |=>
        (!$fell(mem_write_n_o))[*8] ##1 (!$fell(mem_write_n_o))[*2]) else $error("writes close");
    rd_done_a: assert property (rd_take_s |-> ##[13:20] done_o)
        else $error("read late");
    rdy_drop_a: assert property (req_i && ready_o |=> !ready_o)
        else $error("ready held after take");
endmodule // asct_chk

// >>> verif/asct_sram_model.sv
// Behavioural 2M x 16 static memory on the controller's pins
`timescale 1ns/100ps
module asct_sram_model (
    input  logic [20:0] addr_i,
    input  logic        select_low_active_n_i,
    input  logic        select_high_active_i,
    input  logic        we_n_i,
    input  logic        oe_n_i,
    input  logic        upper_lane_enable_n_i,
    input  logic        lower_lane_enable_n_i,
    input  logic [15:0] din_i,
    input  logic        din_oe_i,
    output logic [15:0] dq_o,
    output int          err_o
);
    logic [15:0] mem [int];
    logic [15:0] q = 16'hA5C3;
    logic [20:0] wa;
    logic [1:0]  wl;
    realtime     t0;
    // Read and write enables from the pins
    wire on = !select_low_active_n_i && select_high_active_i;
    wire ln = !(upper_lane_enable_n_i && lower_lane_enable_n_i);
    wire rd = on && we_n_i && !oe_n_i && ln;
    wire wr = on && !we_n_i && ln;
    assign dq_o = din_oe_i ? din_i : q;
    initial err_o = 0;
    // Old word held 10 ns, garbage, then the new word within 54 ns
    always @(addr_i, rd, upper_lane_enable_n_i, lower_lane_enable_n_i)
    begin
        q <= #10 ~q;
        if (rd) q <= #(11 + $urandom % 44)
            {upper_lane_enable_n_i ? ~q[15:8] : mem[addr_i][15:8],
             lower_lane_enable_n_i ? ~q[7:0] : mem[addr_i][7:0]};
    end
    // Write lands when the strobe overlap ends
    always @(posedge wr)
    begin
        t0 = $realtime;
        wa = addr_i;
        wl = {!upper_lane_enable_n_i, !lower_lane_enable_n_i};
    end
    always @(negedge wr)
    begin
        if ($realtime - t0 < 40.0 || addr_i !== wa || !din_oe_i) err_o++;
        if (wl[0]) mem[wa][7:0] = din_i[7:0];
        if (wl[1]) mem[wa][15:8] = din_i[15:8];
    end
    // Both sides on the pins at once
    always @(din_oe_i, rd) if (din_oe_i && rd) err_o++;
endmodule // asct_sram_model

// >>> verif/tb_top.sv
// Random reads and writes through the controller into the memory model
`timescale 1ns/100ps
module tb_top;
    typedef struct {bit rd; logic [15:0] m; logic [15:0] e;} asct_note_t;
    logic        clk_sys_i = 1'b0, rstn_i = 1'b0, req_i = 1'b0, req_write_i = 1'b0;
    logic [20:0] req_addr_i = 21'h000000, mem_addr_o, base;
    logic [15:0] req_wdata_i = 16'h0000, rdata_o, mem_data_o, mem_data_i;
    logic [1:0]  req_lanes_i = 2'h0;
    logic        ready_o, done_o, select_low_active_n_o, select_high_active_o, mem_write_n_o;
    logic        mem_output_n_o, upper_lane_enable_n_o, lower_lane_enable_n_o, mem_data_oe_o;
    int          bad_count = 0, cmp_count = 0, cyc = 0, model_err;
    asct_note_t  notes [$], nt;
    logic [15:0] shadow [int];
    asct_ctrl dut (.clk_sys_i, .rstn_i, .req_i, .req_write_i, .req_addr_i, .req_wdata_i,
        .req_lanes_i, .ready_o, .done_o, .rdata_o, .mem_addr_o, .select_low_active_n_o,
        .select_high_active_o, .mem_write_n_o, .mem_output_n_o, .upper_lane_enable_n_o,
        .lower_lane_enable_n_o, .mem_data_o, .mem_data_oe_o, .mem_data_i);
    asct_sram_model mem_i (.addr_i(mem_addr_o), .select_low_active_n_i(select_low_active_n_o),
        .select_high_active_i(select_high_active_o), .we_n_i(mem_write_n_o),
        .oe_n_i(mem_output_n_o), .upper_lane_enable_n_i(upper_lane_enable_n_o),
        .lower_lane_enable_n_i(lower_lane_enable_n_o), .din_i(mem_data_o),
        .din_oe_i(mem_data_oe_o), .dq_o(mem_data_i), .err_o(model_err));
    // 200 MHz system clock
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    // One comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Hold a request until taken, then note its expected result
    task automatic op(input logic w, input logic [20:0] a, input logic [15:0] d,
                      input logic [1:0] ln);
        logic [15:0] m;
        m = {{8{ln[1]}}, {8{ln[0]}}};
        req_i <= 1'b1;
        req_write_i <= w;
        req_addr_i <= a;
        req_wdata_i <= d;
        req_lanes_i <= ln;
        @(posedge clk_sys_i);
        while (ready_o !== 1'b1) @(posedge clk_sys_i);
        notes.push_back('{!w, m, shadow[a]});
        if (w) shadow[a] = (d & m) | (shadow[a] & ~m);
    endtask
    // Closing report
    task automatic print_verdict();
        bad_count += model_err + notes.size();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Oldest note taken at each completion; hang guard
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (done_o === 1'b1 && notes.size() == 0)
        begin
            bad_count++;
            $display("[ERR] t=%0t done=%h pending=%h", $time, done_o, notes.size());
        end
        else if (done_o === 1'b1)
        begin
            nt = notes.pop_front();
            if (nt.rd) chk(rdata_o & nt.m, nt.e & nt.m);
        end
        if (cyc == 5000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    // Reset, fill eight words, sweep lane codes, then random traffic
    initial
    begin
        void'($urandom(32'h8211D3CD));
        base = 21'($urandom);
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++)
            op(1'b1, base + 21'(i), 16'($urandom), 2'h3);
        for (int i = 0; i < 4; i++)
        begin
            op(1'b1, base, 16'($urandom), 2'(i));
            op(1'b0, base, 16'h0000, 2'h3);
        end
        for (int i = 0; i < 60; i++)
            op(1'($urandom), base + 21'($urandom % 8), 16'($urandom), 2'($urandom));
        req_i <= 1'b0;
        repeat (40) @(posedge clk_sys_i);
        print_verdict();
    end
endmodule // tb_top
// Pin timing checker on the controller
bind asct_ctrl asct_chk chk_i (.clk_sys_i, .rstn_i, .req_i, .req_write_i, .ready_o, .done_o,
    .mem_addr_o, .select_low_active_n_o, .select_high_active_o, .mem_write_n_o,
    .mem_output_n_o, .mem_data_oe_o);
